// ==== bench/rcs_top_asserts.sv ====
// Concurrent checks on the ports of the RTC control settings block.
// Assumes it is bound into rcs_top, all signals on mclk.
`timescale 1ns/1ns
module rcs_top_asserts
    import rcs_pkg::*;
#(
    parameter int WAKE_DIV_W = RCS_WAKE_DIV_W
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire rcs_pkg::rcs_cal_s cal_live,
    input wire logic cal_256hz_level,
    input wire logic cal_1hz_level,
    input wire rcs_pkg::rcs_evt_s evt_flag,
    input wire rcs_pkg::rcs_evt_s irq_req,
    input wire rcs_pkg::rcs_evt_s func_run,
    input wire logic stamp_event,
    input wire logic wake_tick,
    input wire logic mains_ref_sample,
    input wire logic mains_ref_detect_on,
    input wire logic cal_output,
    input wire logic hour_sub_pulse
);
    // ----
    // Port relations
    // ----
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Zero wait, always OKAY
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    irq_gated_a: assert property ((irq_req & ~$past(evt_flag)) == 4'h0)
        else $error("interrupt request without flag");
    stamp_run_a: assert property (stamp_event |-> $past(func_run.stamp))
        else $error("stamp event while disabled");
    stamp_pulse_a: assert property (stamp_event |=> !stamp_event)
        else $error("stamp event longer than one cycle");
    wake_run_a: assert property (wake_tick |-> $past(func_run.wake))
        else $error("wake tick while disabled");
    hour_sub_a: assert property (hour_sub_pulse |-> $past(cal_live.time_word[21:16]) != 6'h00)
        else $error("hour subtracted at hour zero");
    mains_gate_a: assert property (mains_ref_sample |-> $past(mains_ref_detect_on))
        else $error("reference sampled while detection off");
    cal_src_a: assert property (cal_output |-> $past(cal_256hz_level || cal_1hz_level))
        else $error("calibration output without source");
endmodule

// ==== bench/rcs_top_tb.sv ====
// Self-checking bench for the RTC control settings block.
// Assumes rcs_top, rcs_pkg and the checker module in the same compile.
`timescale 1ns/1ns
module rcs_top_tb;
    import rcs_pkg::*;
    logic mclk = '0;
    logic arst_n = '0;
    logic hsel = '0;
    logic hwrite = '0;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    wire logic hready;
    logic [31:0] hrdata;
    logic hreadyout, hresp, cal_output, event_output, stamp_event, mains_ref_sample, mains_ref_detect_on;
    logic wake_tick, wake_reload_ext, hour_add_pulse, hour_sub_pulse, hour_format_ampm, daylight_memo_out;
    logic shadow_synced_flag;
    rcs_evt_s irq_req, func_run;
    rcs_evt_s evt_flag = '0;
    rcs_cal_s cal_live = '0;
    logic cal_256hz_level = '0, cal_1hz_level = '0, sync_prescaler_tick = '0, alarm_a_trig = '0;
    logic alarm_b_trig = '0, wake_trig = '0, stamp_pin = '0, mains_ref_input = '0;
    int errors = 0, total_checks = 0, cyc_n = 0, n_add = 0, n_sub = 0, n_stp = 0, n_wk = 0, n, m;
    logic [31:0] d, t;
    logic [63:0] c;
    assign hready = hreadyout;
    rcs_top u_rcs_top (.mclk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
        .hreadyout, .hresp, .cal_live, .cal_256hz_level, .cal_1hz_level, .sync_prescaler_tick, .evt_flag,
        .alarm_a_trig, .alarm_b_trig, .wake_trig, .stamp_pin, .mains_ref_input, .cal_output, .event_output,
        .irq_req, .func_run, .stamp_event, .mains_ref_sample, .mains_ref_detect_on, .wake_tick,
        .wake_reload_ext, .hour_add_pulse, .hour_sub_pulse, .hour_format_ampm, .daylight_memo_out,
        .shadow_synced_flag);
    // Clock
    initial begin
        forever #25 mclk = ~mclk;
    end
    // Pulse counters and hang guard
    always @(posedge mclk) begin
        n_add += 32'(hour_add_pulse);
        n_sub += 32'(hour_sub_pulse);
        n_stp += 32'(stamp_event);
        n_wk += 32'(wake_tick);
        cyc_n++;
        if (cyc_n > 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic nw(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge mclk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'h1);
        t = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        xfer(a, 1'h1, wd);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'h0, 32'h0);
        chk(t, exp);
    endtask
    task tally_and_finish();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    initial begin
        t = $urandom(83016);
        repeat (20) @(posedge mclk);
        arst_n <= 1'h1;
        rdc(8'h08, RCS_CTRL_RESET);
        rdc(8'h0c, 32'h0);
        // Every output select, polarity and calibration setting with random inputs
        for (int i = 0; i < 32; i++) begin
            // Stamp edge bit stays clear here, so it never changes under an enabled stamp
            d = (i << 19) | ($urandom & 32'hff04_fff7);
            wr(8'h08, d);
            t = $urandom;
            {evt_flag, cal_1hz_level, cal_256hz_level, wake_trig, alarm_b_trig, alarm_a_trig} <= t[8:0];
            nw(2);
            m = (d[22:21] == 2'h0) ? 0 : 32'(t[d[22:21] - 2'h1]);
            chk(32'(event_output), 32'(m[0] ^ d[20]));
            chk(32'(cal_output), 32'(d[23] & (d[19] ? t[4] : t[3])));
            chk({daylight_memo_out, hour_format_ampm}, {d[18], d[6]});
            chk({mains_ref_detect_on, wake_reload_ext}, {d[4], d[2:1] == 2'h3});
            chk({irq_req, func_run}, {t[8:5] & d[15:12], d[11:8]});
            rdc(8'h08, d & RCS_CTRL_WMASK);
        end
        // Wake clock sources, then disabled
        for (int k = 0; k < 9; k++) begin
            wr(8'h08, (k < 8) ? (32'h400 | k) : 32'h3);
            nw(8);
            n = n_wk;
            for (int p = 0; p < 3 && k > 3; p++) begin
                @(posedge mclk);
                sync_prescaler_tick <= 1'h1;
                @(posedge mclk);
                sync_prescaler_tick <= 1'h0;
            end
            nw(64);
            m = (k > 7) ? 0 : (k > 3) ? 3 : 64 >> (4 - k);
            chk(32'(n_wk - n), m);
        end
        // Stamp edge chosen with stamp off, then one pulse each way
        for (int g = 0; g < 2; g++) begin
            wr(8'h08, g << 3);
            stamp_pin <= g[0];
            wr(8'h08, 32'h800 | (g << 3));
            nw(4);
            n = n_stp;
            @(posedge mclk);
            stamp_pin <= !g[0];
            nw(6);
            @(posedge mclk);
            stamp_pin <= g[0];
            nw(6);
            chk(32'(n_stp - n), 32'h1);
        end
        // Hour subtract at zero and nonzero hour, then add
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk);
            cal_live <= {10'h0, k[0] ? 6'h05 : 6'h00, 48'h0};
            nw(1);
            n = n_sub;
            m = n_add;
            wr(8'h08, 32'h1_0000 << (k < 2));
            nw(3);
            chk(32'(n_sub - n), 32'(k == 1));
            chk(32'(n_add - m), 32'(k == 2));
            rdc(8'h08, 32'h0);
        end
        // Live reads in bypass, shadow reads otherwise; bus and kernel share one clock here
        for (int b = 1; b >= 0; b--) begin
            wr(8'h08, b << 5);
            c = {$urandom, $urandom};
            cal_live <= c;
            nw(6);
            chk(32'(shadow_synced_flag), 32'(!b));
            rdc(8'h00, c[63:32]);
            rdc(8'h04, c[31:0]);
        end
        // Reference sampling gated by its enable
        mains_ref_input <= 1'h1;
        wr(8'h08, 32'h10);
        nw(6);
        chk(32'(mains_ref_sample), 32'h1);
        wr(8'h08, 32'h0);
        nw(3);
        chk(32'(mains_ref_sample), 32'h0);
        tally_and_finish();
    end
endmodule
bind rcs_top rcs_top_asserts #(.WAKE_DIV_W(WAKE_DIV_W)) u_rcs_top_asserts (.mclk, .arst_n, .hreadyout, .hresp,
    .cal_live, .cal_256hz_level, .cal_1hz_level, .evt_flag, .irq_req, .func_run, .stamp_event, .wake_tick,
    .mains_ref_sample, .mains_ref_detect_on, .cal_output, .hour_sub_pulse);

// ==== design/rcs_top.sv ====
// Control register and its steering logic for the real-time clock.
// Assumes: one clock mclk acting as the kernel clock, an AHB-Lite master,
// calendar counters, prescaler ticks and status flags on the same clock.
//
// Functional notes
// - Calibration output toggles only while its enable bit 23 is set.
// - Field 22:21 picks event output: off, alarm A, alarm B, wakeup.
// - Bit 20 clear: trigger drives output high; set: drives it low.
// - Bit 19 picks 256 Hz or 1 Hz calibration rate at default prescale.
// - Bit 18 is a software memo with no effect on counting.
// - Writing 1 to bit 17 subtracts an hour unless hour is zero; reads 0.
// - Writing 1 to bit 16 adds one hour; writing 0 nothing; reads 0.
// - Interrupt requests for four events pass only when enabled.
// - Timestamp, wakeup, alarm B and A run only while enabled.
// - Bypass clear: reads give shadows refreshed every two cycles; set: live.
// - Mains reference detection works only while bit 4 is set.
// - Bit 3 clear: rising stamp edge makes event; set: falling edge.
// - Wake clock codes 000 to 011 divide kernel clock by 16, 8, 4, 2.
// - Wake clock codes 10x use the synchronous prescaler tick.
// - Wake clock codes 11x use that tick and extend reload by 2^16.
// - Hour format bit picks 24-hour or AM/PM counting.
// - Shadow synced flag stays clear while bypass is selected.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
module rcs_top
    import rcs_pkg::*;
#(
    parameter int WAKE_DIV_W = RCS_WAKE_DIV_W
) (
    input wire logic mclk,
    input wire logic arst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Calendar, prescaler and status side
    input wire rcs_pkg::rcs_cal_s cal_live,
    input wire logic cal_256hz_level,
    input wire logic cal_1hz_level,
    input wire logic sync_prescaler_tick,
    input wire rcs_pkg::rcs_evt_s evt_flag,
    input wire logic alarm_a_trig,
    input wire logic alarm_b_trig,
    input wire logic wake_trig,
    // Pins
    input wire logic stamp_pin,
    input wire logic mains_ref_input,
    output logic cal_output,
    output logic event_output,
    // Towards the other RTC functions
    output rcs_pkg::rcs_evt_s irq_req,
    output rcs_pkg::rcs_evt_s func_run,
    output logic stamp_event,
    output logic mains_ref_sample,
    output logic mains_ref_detect_on,
    output logic wake_tick,
    output logic wake_reload_ext,
    output logic hour_add_pulse,
    output logic hour_sub_pulse,
    output logic hour_format_ampm,
    output logic daylight_memo_out,
    output logic shadow_synced_flag
);
    import rcs_pkg::*;

    initial begin
        if (WAKE_DIV_W < 4 || WAKE_DIV_W > 8) begin
            $error("WAKE_DIV_W must be 4 to 8");
        end
    end

    // ---------------------------------------------
    // Bus slave
    // ---------------------------------------------
    rcs_ctrl_s ctrl;
    logic ap_write;
    logic ap_read;
    logic [7:0] ap_addr;
    logic [31:0] shadow_time;
    logic [31:0] shadow_date;
    logic [31:0] next_rdata;
    logic ctrl_wr;
    logic [5:0] live_hour;

    // Address phase capture; always zero wait states
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ap_write <= 1'b0;
            ap_read <= 1'b0;
            ap_addr <= 8'h00;
        end else if (hready) begin
            ap_write <= hsel && htrans[1] && hwrite;
            ap_read <= hsel && htrans[1] && !hwrite;
            ap_addr <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ctrl_wr = ap_write && (ap_addr == RCS_CTRL_OFS);
    assign live_hour = cal_live.time_word[RCS_HOUR_MSB:RCS_HOUR_LSB];

    // Read mux in the address phase; unmapped reads give zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (haddr[7:0])
            RCS_TIME_OFS: begin
                next_rdata = ctrl.shadow_bypass ? cal_live.time_word : shadow_time;
            end
            RCS_DATE_OFS: begin
                next_rdata = ctrl.shadow_bypass ? cal_live.date_word : shadow_date;
            end
            RCS_CTRL_OFS: begin
                // Forward a write still in its data phase, else a read right behind it gets stale bits
                next_rdata = ctrl_wr ? (hwdata & RCS_CTRL_WMASK) : (ctrl & RCS_CTRL_WMASK);
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data register, shown in the data phase
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ---------------------------------------------
    // Control register
    // ---------------------------------------------
    // Memo bit 18 is stored, read back and driven on daylight_memo_out
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= RCS_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl <= hwdata & RCS_CTRL_WMASK;
        end
    end

    // One-shot hour adjust strobes, never stored
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hour_add_pulse <= 1'b0;
            hour_sub_pulse <= 1'b0;
        end else begin
            hour_add_pulse <= ctrl_wr && hwdata[RCS_ADD_HOUR_BIT];
            hour_sub_pulse <= ctrl_wr && hwdata[RCS_SUB_HOUR_BIT]
                && (live_hour != 6'h00);
        end
    end

    assign daylight_memo_out = ctrl.daylight_memo;
    assign hour_format_ampm = ctrl.hour_format;

    // ---------------------------------------------
    // Shadow copies
    // ---------------------------------------------
    logic [$clog2(RCS_SHADOW_PERIOD)-1:0] shadow_cnt;
    logic shadow_load;

    assign shadow_load = (shadow_cnt == ($clog2(RCS_SHADOW_PERIOD))'(RCS_SHADOW_PERIOD - 1));

    // Copy every second kernel cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            shadow_cnt <= '0;
            shadow_time <= 32'h0000_0000;
            shadow_date <= 32'h0000_0000;
        end else begin
            shadow_cnt <= shadow_load ? '0 : shadow_cnt + 1'b1;
            if (shadow_load) begin
                shadow_time <= cal_live.time_word;
                shadow_date <= cal_live.date_word;
            end
        end
    end

    // Synced flag: held clear in bypass, set on each copy
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            shadow_synced_flag <= 1'b0;
        end else if (ctrl.shadow_bypass) begin
            shadow_synced_flag <= 1'b0;
        end else if (shadow_load) begin
            shadow_synced_flag <= 1'b1;
        end
    end

    // ---------------------------------------------
    // Enables and interrupt gating
    // ---------------------------------------------
    assign func_run.stamp = ctrl.stamp_enable;
    assign func_run.wake = ctrl.wake_timer_enable;
    assign func_run.alarm_b = ctrl.alarm_b_enable;
    assign func_run.alarm_a = ctrl.alarm_a_enable;

    // Flags reach the interrupt only when enabled
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_req <= '0;
        end else begin
            irq_req.stamp <= evt_flag.stamp && ctrl.stamp_irq_enable;
            irq_req.wake <= evt_flag.wake && ctrl.wake_irq_enable;
            irq_req.alarm_b <= evt_flag.alarm_b && ctrl.alarm_b_irq_enable;
            irq_req.alarm_a <= evt_flag.alarm_a && ctrl.alarm_a_irq_enable;
        end
    end

    // ---------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------
    logic [1:0] stamp_sync;
    logic [1:0] ref_sync;
    logic stamp_prev;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stamp_sync <= 2'b00;
            ref_sync <= 2'b00;
            stamp_prev <= 1'b0;
        end else begin
            stamp_sync <= {stamp_sync[0], stamp_pin};
            ref_sync <= {ref_sync[0], mains_ref_input};
            stamp_prev <= stamp_sync[1];
        end
    end

    // Edge select picks rising or falling; only while enabled
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stamp_event <= 1'b0;
        end else begin
            stamp_event <= ctrl.stamp_enable && (ctrl.stamp_edge_select
                ? (stamp_prev && !stamp_sync[1])
                : (!stamp_prev && stamp_sync[1]));
        end
    end

    // Reference input passed on only while detection is on
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mains_ref_sample <= 1'b0;
        end else begin
            mains_ref_sample <= ctrl.mains_ref_detect_enable && ref_sync[1];
        end
    end

    assign mains_ref_detect_on = ctrl.mains_ref_detect_enable;

    // ---------------------------------------------
    // Wakeup clock selection
    // ---------------------------------------------
    logic [WAKE_DIV_W-1:0] wake_div;
    logic div_hit;

    // Divide by 16, 8, 4 or 2 from the low divider bits
    always_comb begin
        case (ctrl.wake_clock_select)
            3'b000: div_hit = (wake_div[3:0] == 4'hf);
            3'b001: div_hit = (wake_div[2:0] == 3'h7);
            3'b010: div_hit = (wake_div[1:0] == 2'h3);
            3'b011: div_hit = wake_div[0];
            default: div_hit = sync_prescaler_tick;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wake_div <= '0;
            wake_tick <= 1'b0;
        end else begin
            wake_div <= wake_div + 1'b1;
            wake_tick <= ctrl.wake_timer_enable && div_hit;
        end
    end

    assign wake_reload_ext = (ctrl.wake_clock_select[2:1] == 2'b11);

    // ---------------------------------------------
    // Output pins
    // ---------------------------------------------
    logic sel_trig;

    // Source of the event output
    always_comb begin
        case (ctrl.event_out_select)
            RCS_OUT_OFF: sel_trig = 1'b0;
            RCS_OUT_ALARM_A: sel_trig = alarm_a_trig;
            RCS_OUT_ALARM_B: sel_trig = alarm_b_trig;
            RCS_OUT_WAKE: sel_trig = wake_trig;
            default: sel_trig = 1'b0;
        endcase
    end

    // Polarity and calibration rate
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            event_output <= 1'b0;
            cal_output <= 1'b0;
        end else begin
            event_output <= sel_trig ^ ctrl.event_out_polarity;
            cal_output <= ctrl.cal_out_enable
                && (ctrl.cal_out_rate_select ? cal_1hz_level : cal_256hz_level);
        end
    end

endmodule

// ==== pkg/rcs_pkg.sv ====
// Shared constants and types for the RTC control settings block.
// Assumes an AHB-Lite slave with 32-bit data and word registers.
package rcs_pkg;

    // ---------------------------------------------
    // Register map
    // ---------------------------------------------
    localparam logic [7:0] RCS_TIME_OFS = 8'h00;
    localparam logic [7:0] RCS_DATE_OFS = 8'h04;
    localparam logic [7:0] RCS_CTRL_OFS = 8'h08;
    localparam logic [31:0] RCS_CTRL_RESET = 32'h0000_0000;
    // Bits that store; 31:24, 17, 16 and 7 never hold a value
    localparam logic [31:0] RCS_CTRL_WMASK = 32'h00fc_ff7f;
    localparam int RCS_SUB_HOUR_BIT = 17;
    localparam int RCS_ADD_HOUR_BIT = 16;
    // Hour field of the time word
    localparam int RCS_HOUR_LSB = 16;
    localparam int RCS_HOUR_MSB = 21;

    // ---------------------------------------------
    // Timing
    // ---------------------------------------------
    localparam int RCS_SHADOW_PERIOD = 2;      // kernel clock cycles per shadow copy
    localparam int RCS_WAKE_DIV_W = 4;         // widest kernel divider is by 16

    // ---------------------------------------------
    // Event output sources
    // ---------------------------------------------
    typedef enum logic [1:0] {
        RCS_OUT_OFF = 2'b00,
        RCS_OUT_ALARM_A = 2'b01,
        RCS_OUT_ALARM_B = 2'b10,
        RCS_OUT_WAKE = 2'b11
    } rcs_out_sel_e;

    // Control register layout, bit 31 first
    typedef struct packed {
        logic [7:0] reserved_hi;
        logic cal_out_enable;
        rcs_out_sel_e event_out_select;
        logic event_out_polarity;
        logic cal_out_rate_select;
        logic daylight_memo;
        logic hour_minus_one;
        logic hour_plus_one;
        logic stamp_irq_enable;
        logic wake_irq_enable;
        logic alarm_b_irq_enable;
        logic alarm_a_irq_enable;
        logic stamp_enable;
        logic wake_timer_enable;
        logic alarm_b_enable;
        logic alarm_a_enable;
        logic reserved_7;
        logic hour_format;
        logic shadow_bypass;
        logic mains_ref_detect_enable;
        logic stamp_edge_select;
        logic [2:0] wake_clock_select;
    } rcs_ctrl_s;

    // Live calendar words from the counters
    typedef struct packed {
        logic [31:0] time_word;
        logic [31:0] date_word;
    } rcs_cal_s;

    // Event flags from the status logic
    typedef struct packed {
        logic stamp;
        logic wake;
        logic alarm_b;
        logic alarm_a;
    } rcs_evt_s;

endpackage
